// file: hwis_core_model.sv
// Core stand-in: instruction ends, returns, global mask
`timescale 1ns/100ps
`default_nettype none
module hwis_core_model (
    input  wire core_clk,
    input  wire rst,
    input  wire core_hold,
    input  wire set_mask,
    input  wire irq_ack,
    output reg  instr_done = 1'b0,
    output reg  instr_is_rti = 1'b0,
    output reg  mask_bit = 1'b0
);
    reg [1:0] gap_reg = 2'h0;
    reg       tog_reg = 1'b0;
    integer   depth = 0;
    always @(posedge core_clk) begin
        if (rst) begin
            instr_done <= #1 1'b0;
            mask_bit <= #1 1'b0;
            depth = 0;
        end else begin
            // Handler body opaque; index high kept by software
            depth = depth + irq_ack - (instr_done && instr_is_rti);
            if (set_mask)
                mask_bit <= #1 1'b1;
            if (instr_done && instr_is_rti)
                mask_bit <= #1 1'b0;
            // No new boundary while the sequencer owns the core
            instr_done <= #1 !core_hold && !instr_done && gap_reg == 2'h3;
            instr_is_rti <= #1 depth > 0 && tog_reg;
            if (!core_hold && !instr_done)
                gap_reg <= #1 gap_reg + 2'h1;
            if (gap_reg == 2'h3)
                tog_reg <= #1 ~tog_reg;
        end
    end
endmodule // hwis_core_model
`default_nettype wire

// file: hwis_defs.vh
// Constants for the hardware interrupt sequencer
`ifndef HWIS_DEFS_VH
`define HWIS_DEFS_VH
`define HWIS_NUM_SRC        8
`define HWIS_IDX_W          3
`define HWIS_ST_W           4
`define HWIS_ST_RUN         4'h0
`define HWIS_ST_DUMMY       4'h1
`define HWIS_ST_PUSH_PCL    4'h2
`define HWIS_ST_PUSH_PCH    4'h3
`define HWIS_ST_PUSH_XL     4'h4
`define HWIS_ST_PUSH_ACC    4'h5
`define HWIS_ST_PUSH_CCR    4'h6
`define HWIS_ST_VECT_H      4'h7
`define HWIS_ST_VECT_L      4'h8
`define HWIS_ST_PULL_CCR    4'h9
`define HWIS_ST_PULL_ACC    4'hA
`define HWIS_ST_PULL_XL     4'hB
`define HWIS_ST_PULL_PCH    4'hC
`define HWIS_ST_PULL_PCL    4'hD
`define HWIS_ST_PREFETCH    4'hE
`define HWIS_STEP_PUSH      3'h1
`define HWIS_STEP_IBIT      3'h2
`define HWIS_STEP_VECT_H    3'h3
`define HWIS_STEP_VECT_L    3'h4
`define HWIS_STEP_PULL      3'h5
`define HWIS_STEP_FETCH     3'h6
`define HWIS_STEP_NONE      3'h0
`endif

// file: hwis_prio.v
// Fixed-priority picker: lowest index wins
`timescale 1ns/100ps
`default_nettype none
module hwis_prio #(
    parameter N = 8,
    parameter W = 3
) (
    input  wire [N-1:0] req,
    output reg          any,
    output reg  [W-1:0] idx
);
    integer i;
    always @* begin
        any = 1'b0;
        idx = {W{1'b0}};
        for (i = N - 1; i >= 0; i = i - 1) begin
            if (req[i]) begin
                any = 1'b1;
                idx = i[W-1:0];
            end
        end
    end
endmodule // hwis_prio
`default_nettype wire

// file: hwis_seq.v
// Hardware interrupt sequencer between sources and the core
`timescale 1ns/100ps
`default_nettype none
`include "hwis_defs.vh"
// Functional notes
// [RULE1] Running instruction always completes normally
// [RULE2] Interrupt sequence starts only at boundaries
// [RULE3] Sample all pending requests at completion
// [RULE4] Enter only if mask clear, enabled
// [RULE5] No qualifier: next fetch, no cycles
// [RULE6] Highest priority first, others stay pending
// [RULE7] Pending after return serviced before next
// [RULE8] Return always prefetches restored opcode
// [RULE9] Index high byte never stacked
// [RULE10] Software saves index high byte itself
// [RULE11] Set mask after stacking, before vector
// [RULE12] Return pulls stack in reverse order
module hwis_seq #(
    parameter N = `HWIS_NUM_SRC,
    parameter W = `HWIS_IDX_W
) (
    input  wire         core_clk,
    input  wire         rst,
    input  wire         instr_done,
    input  wire         instr_is_rti,
    input  wire [N-1:0] irq_pending,
    input  wire [N-1:0] irq_enable,
    input  wire         mask_bit,
    output reg          core_hold,
    output reg          fetch_next,
    output reg          set_mask,
    output reg          irq_ack,
    output reg  [W-1:0] irq_ack_idx,
    output reg  [W-1:0] vector_idx,
    output reg  [2:0]   bus_step,
    output reg  [3:0]   seq_state,
    output reg          stack_index_high
);
    // Sequencer states, binary coded
    localparam [`HWIS_ST_W-1:0] ST_RUN      = `HWIS_ST_RUN;
    localparam [`HWIS_ST_W-1:0] ST_DUMMY    = `HWIS_ST_DUMMY;
    localparam [`HWIS_ST_W-1:0] ST_PUSH_PCL = `HWIS_ST_PUSH_PCL;
    localparam [`HWIS_ST_W-1:0] ST_PUSH_PCH = `HWIS_ST_PUSH_PCH;
    localparam [`HWIS_ST_W-1:0] ST_PUSH_XL  = `HWIS_ST_PUSH_XL;
    localparam [`HWIS_ST_W-1:0] ST_PUSH_ACC = `HWIS_ST_PUSH_ACC;
    localparam [`HWIS_ST_W-1:0] ST_PUSH_CCR = `HWIS_ST_PUSH_CCR;
    localparam [`HWIS_ST_W-1:0] ST_VECT_H   = `HWIS_ST_VECT_H;
    localparam [`HWIS_ST_W-1:0] ST_VECT_L   = `HWIS_ST_VECT_L;
    localparam [`HWIS_ST_W-1:0] ST_PULL_CCR = `HWIS_ST_PULL_CCR;
    localparam [`HWIS_ST_W-1:0] ST_PULL_ACC = `HWIS_ST_PULL_ACC;
    localparam [`HWIS_ST_W-1:0] ST_PULL_XL  = `HWIS_ST_PULL_XL;
    localparam [`HWIS_ST_W-1:0] ST_PULL_PCH = `HWIS_ST_PULL_PCH;
    localparam [`HWIS_ST_W-1:0] ST_PULL_PCL = `HWIS_ST_PULL_PCL;
    localparam [`HWIS_ST_W-1:0] ST_PREFETCH = `HWIS_ST_PREFETCH;

    // Bus step codes shown to the core
    localparam [2:0] STEP_NONE   = `HWIS_STEP_NONE;
    localparam [2:0] STEP_PUSH   = `HWIS_STEP_PUSH;
    localparam [2:0] STEP_VECT_H = `HWIS_STEP_VECT_H;
    localparam [2:0] STEP_VECT_L = `HWIS_STEP_VECT_L;
    localparam [2:0] STEP_PULL   = `HWIS_STEP_PULL;
    localparam [2:0] STEP_FETCH  = `HWIS_STEP_FETCH;

    reg  [`HWIS_ST_W-1:0] state_reg;
    reg  [`HWIS_ST_W-1:0] state_next;
    reg  [W-1:0]          idx_reg;
    reg                   mask_seen_reg;
    reg  [2:0]            step_next;
    wire [N-1:0]          qual;
    wire                  any_q;
    wire [W-1:0]          win_idx;
    wire                  mask_eff;
    wire                  boundary;
    wire                  take;
    wire                  retake;
    wire                  grant;

    // Mask follows the core, or our own set during entry
    assign mask_eff = mask_bit | mask_seen_reg;
    assign qual     = irq_pending & irq_enable & {N{~mask_eff}}; // [RULE4]

    hwis_prio #(.N(N), .W(W)) u_prio (
        .req (qual),
        .any (any_q),
        .idx (win_idx)
    );

    // Sample only while running and at completion
    assign boundary = (state_reg == ST_RUN) & instr_done; // [RULE2] [RULE3]
    // Return boundary never takes; its prefetch decides instead
    assign take     = boundary & ~instr_is_rti & any_q;   // [RULE1]
    assign retake   = (state_reg == ST_PREFETCH) & any_q; // [RULE7]
    assign grant    = take | retake;

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN: begin
                if (boundary & instr_is_rti) begin
                    state_next = ST_PULL_CCR; // [RULE12]
                end else if (take) begin
                    state_next = ST_DUMMY;
                end
            end
            // Index high skipped: stack frame is five bytes
            ST_DUMMY:    state_next = ST_PUSH_PCL;
            ST_PUSH_PCL: state_next = ST_PUSH_PCH;
            ST_PUSH_PCH: state_next = ST_PUSH_XL; // [RULE9]
            ST_PUSH_XL:  state_next = ST_PUSH_ACC;
            ST_PUSH_ACC: state_next = ST_PUSH_CCR;
            ST_PUSH_CCR: state_next = ST_VECT_H;
            ST_VECT_H:   state_next = ST_VECT_L;
            ST_VECT_L:   state_next = ST_RUN;
            ST_PULL_CCR: state_next = ST_PULL_ACC; // [RULE12]
            ST_PULL_ACC: state_next = ST_PULL_XL;
            ST_PULL_XL:  state_next = ST_PULL_PCH;
            ST_PULL_PCH: state_next = ST_PULL_PCL;
            ST_PULL_PCL: state_next = ST_PREFETCH;
            ST_PREFETCH: begin
                // Prefetch done even if discarded below
                if (any_q) begin
                    state_next = ST_DUMMY; // [RULE7] [RULE8]
                end else begin
                    state_next = ST_RUN;
                end
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
    end

    // Step code follows the state being entered
    always @* begin
        case (state_next)
            ST_PUSH_PCL, ST_PUSH_PCH, ST_PUSH_XL,
            ST_PUSH_ACC, ST_PUSH_CCR: begin
                step_next = STEP_PUSH;
            end
            ST_VECT_H: begin
                step_next = STEP_VECT_H;
            end
            ST_VECT_L: begin
                step_next = STEP_VECT_L;
            end
            ST_PULL_CCR, ST_PULL_ACC, ST_PULL_XL,
            ST_PULL_PCH, ST_PULL_PCL: begin
                step_next = STEP_PULL;
            end
            ST_PREFETCH: begin
                step_next = STEP_FETCH; // [RULE8]
            end
            default: begin
                step_next = STEP_NONE;
            end
        endcase
    end

    always @(posedge core_clk) begin
        if (rst) begin
            state_reg <= ST_RUN;
            seq_state <= ST_RUN;
            core_hold <= 1'b0;
            bus_step  <= STEP_NONE;
        end else begin
            state_reg <= state_next;
            seq_state <= state_next;
            core_hold <= (state_next != ST_RUN);
            bus_step  <= step_next;
        end
    end

    // Latch winner once; later requests wait their turn
    always @(posedge core_clk) begin
        if (rst) begin
            idx_reg     <= {W{1'b0}};
            irq_ack     <= 1'b0;
            irq_ack_idx <= {W{1'b0}};
            vector_idx  <= {W{1'b0}};
        end else begin
            irq_ack <= grant;
            if (grant) begin
                idx_reg     <= win_idx; // [RULE6]
                irq_ack_idx <= win_idx;
            end
            // Vector follows the winner from its first cycle
            vector_idx <= grant ? win_idx : idx_reg;
        end
    end

    // Bridge the core's mask update latency
    always @(posedge core_clk) begin
        if (rst) begin
            mask_seen_reg <= 1'b0;
            set_mask      <= 1'b0;
        end else begin
            set_mask <= (state_reg == ST_PUSH_CCR); // [RULE11]
            if (state_reg == ST_PUSH_CCR) begin
                mask_seen_reg <= 1'b1;
            end else if (state_reg == ST_PULL_CCR) begin
                mask_seen_reg <= 1'b0;
            end
        end
    end

    // One fetch strobe per way back to normal flow
    always @(posedge core_clk) begin
        if (rst) begin
            fetch_next       <= 1'b0;
            stack_index_high <= 1'b0;
        end else begin
            stack_index_high <= 1'b0; // [RULE9]
            if (boundary & ~instr_is_rti & ~take) begin
                fetch_next <= 1'b1; // [RULE5]
            end else if (state_reg == ST_VECT_L) begin
                fetch_next <= 1'b1;
            end else if ((state_reg == ST_PREFETCH) & ~any_q) begin
                fetch_next <= 1'b1; // [RULE8]
            end else begin
                fetch_next <= 1'b0;
            end
        end
    end
endmodule // hwis_seq
`default_nettype wire

// file: hwis_seq_props.sv
// Port timing checks for the interrupt sequencer
`timescale 1ns/100ps
`default_nettype none
module hwis_seq_props (
    input wire       core_clk,
    input wire       rst,
    input wire       instr_done,
    input wire       instr_is_rti,
    input wire [7:0] irq_pending,
    input wire [7:0] irq_enable,
    input wire       mask_bit,
    input wire       core_hold,
    input wire       fetch_next,
    input wire       set_mask,
    input wire       irq_ack,
    input wire [2:0] irq_ack_idx,
    input wire [2:0] vector_idx,
    input wire [2:0] bus_step,
    input wire [3:0] seq_state,
    input wire       stack_index_high
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    wire [7:0] q = irq_pending & irq_enable & {8{~mask_bit}};
    wire [7:0] lowm = (8'h01 << irq_ack_idx) - 8'h01;
    wire       tk = instr_done && !core_hold;
    wire       rf = bus_step == 3'h6;
    reg  [7:0] q_d;
    always @(posedge core_clk) q_d <= q;
    sequence entry_s;
        (bus_step == 3'h1 && !set_mask) [*5] ##1 (bus_step == 3'h3 && set_mask)
        ##1 bus_step == 3'h4 ##1 (fetch_next && !core_hold);
    endsequence
    // Pull states CCR, ACC, XL, PCH, PCL, then prefetch
    sequence pull_s;
        seq_state == 4'h9 ##1 seq_state == 4'hA ##1 seq_state == 4'hB
        ##1 seq_state == 4'hC ##1 seq_state == 4'hD ##1 rf;
    endsequence
    chk_take_ack: assert property (tk && !instr_is_rti && q != 0
        |=> irq_ack && core_hold) else $error("request not taken");
    chk_idle_fetch: assert property (tk && !instr_is_rti && q == 0
        |=> fetch_next && !core_hold) else $error("idle boundary stalled");
    chk_prio_pick: assert property (irq_ack
        |-> q_d[irq_ack_idx] && (q_d & lowm) == 8'h00) else $error("bad pick");
    chk_entry_order: assert property (irq_ack |=> entry_s)
        else $error("entry order wrong");
    chk_return_order: assert property (tk && instr_is_rti |=> pull_s)
        else $error("return order wrong");
    chk_pend_again: assert property (rf && q != 0 |=> irq_ack)
        else $error("pending after return missed");
    chk_return_free: assert property (rf && q == 0 |=> fetch_next)
        else $error("no fetch after return");
    chk_hold_cause: assert property ($rose(core_hold) |-> $past(tk))
        else $error("hold without boundary");
    chk_index_high: assert property (!stack_index_high)
        else $error("index high stacked");
    chk_vector_pick: assert property (bus_step == 3'h3
        |-> vector_idx == irq_ack_idx) else $error("vector index wrong");
endmodule // hwis_seq_props
`default_nettype wire

// file: hwis_tb.sv
// Random source traffic against a reference of the sequencer
`timescale 1ns/100ps
`default_nettype none
module testbench;
    reg        core_clk = 1'b0;
    reg        rst = 1'b1;
    reg  [7:0] irq_pending = 8'h00;
    reg  [7:0] irq_enable = 8'h00;
    wire       instr_done, instr_is_rti, mask_bit, core_hold;
    wire       fetch_next, set_mask, irq_ack, stack_index_high;
    wire [2:0] irq_ack_idx;
    integer    seed = 32'h87B0, failures = 0, cmp_count = 0, rcnt = -1, i;
    reg  [7:0] q;
    reg        due = 1'b0, e_ack;
    reg  [2:0] e_idx;
    always #5 core_clk = ~core_clk;
    hwis_seq dut (.core_clk(core_clk), .rst(rst), .instr_done(instr_done),
        .instr_is_rti(instr_is_rti), .irq_pending(irq_pending),
        .irq_enable(irq_enable), .mask_bit(mask_bit), .core_hold(core_hold),
        .fetch_next(fetch_next), .set_mask(set_mask), .irq_ack(irq_ack),
        .irq_ack_idx(irq_ack_idx), .vector_idx(), .bus_step(), .seq_state(),
        .stack_index_high(stack_index_high));
    hwis_core_model core (.core_clk(core_clk), .rst(rst),
        .core_hold(core_hold), .set_mask(set_mask), .irq_ack(irq_ack),
        .instr_done(instr_done), .instr_is_rti(instr_is_rti),
        .mask_bit(mask_bit));
    task check(input a, input b);
        begin
            cmp_count = cmp_count + 1;
            if (a !== b) begin
                failures = failures + 1;
                $display("BAD %0t result mismatch", $time);
            end
        end
    endtask
    // Sources drop a request once it is acknowledged
    always @(posedge core_clk) begin
        if (irq_ack)
            irq_pending <= #1 irq_pending & ~(8'h01 << irq_ack_idx);
        else if (!core_hold && $random(seed) % 4 == 0) begin
            irq_pending <= #1 irq_pending | 8'($random(seed));
            irq_enable <= #1 8'($random(seed));
        end
    end
    always @(negedge core_clk) if (!rst) begin
        if (due) begin
            check(irq_ack, e_ack);
            check(fetch_next, !e_ack);
            check(!e_ack || irq_ack_idx === e_idx, 1'b1);
        end
        if (rcnt >= 0)
            rcnt = rcnt - 1;
        q = irq_pending & irq_enable & {8{~mask_bit}};
        due = (instr_done && !core_hold && !instr_is_rti) || rcnt == 0;
        e_ack = q != 8'h00;
        for (i = 7; i >= 0; i = i - 1)
            if (q[i])
                e_idx = i[2:0];
        // Return decides six cycles after it is taken
        if (instr_done && !core_hold && instr_is_rti)
            rcnt = 6;
    end
    initial begin
        repeat (8) @(posedge core_clk);
        rst <= #1 1'b0;
        repeat (5000) @(posedge core_clk);
        final_report;
    end
    initial begin
        #60000;
        failures = failures + 1;
        final_report;
    end
    task final_report;
        begin
            if (failures == 0 && cmp_count > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
endmodule // testbench
bind hwis_seq hwis_seq_props chk (
    .core_clk         (core_clk),
    .rst              (rst),
    .instr_done       (instr_done),
    .instr_is_rti     (instr_is_rti),
    .irq_pending      (irq_pending),
    .irq_enable       (irq_enable),
    .mask_bit         (mask_bit),
    .core_hold        (core_hold),
    .fetch_next       (fetch_next),
    .set_mask         (set_mask),
    .irq_ack          (irq_ack),
    .irq_ack_idx      (irq_ack_idx),
    .vector_idx       (vector_idx),
    .bus_step         (bus_step),
    .seq_state        (seq_state),
    .stack_index_high (stack_index_high)
);
`default_nettype wire
